//--- dv/brps_link_sva.sv
`timescale 1ns/1ns
module brps_link_sva #(
	parameter int PWR_WAIT_CYC = brps_pkg::PERST_PWR_WAIT_CYC,
	parameter int CLK_WAIT_CYC = brps_pkg::PERST_CLK_WAIT_CYC
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Link lines
	input wire logic i_perst_n,
	input wire logic i_global_reset_n,
	input wire logic i_refclk,
	input wire logic i_supplies_on,
	input wire logic i_io_clamp_rail
);
	logic [23:0] clk_q;
	logic [23:0] pwr_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_srst);

	// Cycles since clock activity and since supplies came up
	always_ff @(posedge i_ref_clk) begin
		if (i_srst || !i_io_clamp_rail) clk_q <= '0;
		else if ((i_refclk || clk_q != '0) && clk_q != '1) clk_q <= clk_q + 24'h000001;
		if (i_srst || !i_supplies_on) pwr_q <= '0;
		else if (pwr_q != '1) pwr_q <= pwr_q + 24'h000001;
	end

	chk_perst_before_power: assert property ($rose(i_supplies_on) |-> !i_perst_n)
		else $error("supplies rose with reset released");
	chk_clamp_needs_supply: assert property (i_io_clamp_rail |-> i_supplies_on)
		else $error("clamp rail on without supplies");
	chk_clock_needs_clamp: assert property ($changed(i_refclk) |-> i_io_clamp_rail)
		else $error("reference clock active without clamp rail");
	// Margin covers the toggle seen late through the counter
	chk_clock_wait_met: assert property ($rose(i_perst_n) |-> clk_q >= 24'(CLK_WAIT_CYC - 4))
		else $error("reset released too soon after clock");
	chk_power_wait_met: assert property ($rose(i_perst_n) |-> pwr_q >= 24'(PWR_WAIT_CYC))
		else $error("reset released too soon after power");
	chk_clock_runs_released: assert property (i_perst_n && $past(i_perst_n, 2)
		|-> i_refclk != $past(i_refclk, 2))
		else $error("clock stopped while reset released");
	chk_clamp_off_order: assert property ($fell(i_io_clamp_rail) |->
		!i_perst_n ##1 $stable(i_refclk))
		else $error("clamp removed before reset or clock stop");
	// Clamp must already be gone in the cycle before the supplies drop
	chk_supply_off_order: assert property ($fell(i_supplies_on)
		|-> !$past(i_io_clamp_rail) && !i_perst_n)
		else $error("supplies removed out of order");
	chk_unpowered_in_reset: assert property (!i_supplies_on |-> !i_perst_n)
		else $error("reset released while unpowered");

	// Main scenarios
	cov_release: cover property ($rose(i_perst_n));
	cov_power_down: cover property ($fell(i_supplies_on));
	cov_clamp_off: cover property ($fell(i_io_clamp_rail));
	cov_global: cover property ($fell(i_global_reset_n));
endmodule // brps_link_sva

//--- dv/tb_bridge_reset_power_sequencing.sv
`timescale 1ns/1ns
module tb_bridge_reset_power_sequencing;
	localparam int LIM = 4000;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic i_power_on = 1'b0;
	logic i_global_reset_req = 1'b0;
	logic i_eeprom_present = 1'b0;
	logic [7:0] supply = 8'h00;
	logic [7:0] straps = 8'h00;
	logic o_full_rst, o_nonsticky_rst, o_secondary_bus_reset_out, o_eeprom_load_start;
	logic o_link_train_start, o_link_train_en, o_perst_seen, o_power_good, o_seq_busy;
	logic [7:0] o_straps_q;
	int miscompares = 0;
	int tests_run = 0;
	int n;

	brps_link_if i_brps_link_if ();
	brps_bridge i_brps_bridge (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .link(i_brps_link_if),
		.i_core_supply_sense(supply), .i_straps(straps), .i_eeprom_present(i_eeprom_present),
		.o_full_rst(o_full_rst), .o_nonsticky_rst(o_nonsticky_rst),
		.o_secondary_bus_reset_out(o_secondary_bus_reset_out), .o_straps_q(o_straps_q),
		.o_eeprom_load_start(o_eeprom_load_start), .o_link_train_start(o_link_train_start),
		.o_link_train_en(o_link_train_en), .o_perst_seen(o_perst_seen));
	brps_system #(.PWR_WAIT_CYC(200), .CLK_WAIT_CYC(50)) i_brps_system (.i_ref_clk(i_ref_clk),
		.i_srst(i_srst), .i_power_on(i_power_on), .i_global_reset_req(i_global_reset_req),
		.link(i_brps_link_if), .o_power_good(o_power_good), .o_seq_busy(o_seq_busy));
	brps_link_sva #(.PWR_WAIT_CYC(200), .CLK_WAIT_CYC(50)) i_brps_link_sva (
		.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_perst_n(i_brps_link_if.perst_n),
		.i_global_reset_n(i_brps_link_if.global_reset_n), .i_refclk(i_brps_link_if.refclk),
		.i_supplies_on(i_brps_link_if.supplies_on),
		.i_io_clamp_rail(i_brps_link_if.io_clamp_rail));

	// Clock at 125 MHz
	always #4 i_ref_clk = ~i_ref_clk;

	// Compare and count
	task check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("Compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// A used-up wait ends the run
	task bound(input int k);
		if (k >= LIM) begin
			miscompares++;
			give_verdict();
		end
	endtask

	task cyc(input int k);
		repeat (k) @(negedge i_ref_clk);
	endtask

	// Request power and wait for reset release on the link
	task power_up;
		i_power_on = 1'b1;
		for (n = 0; n < LIM && o_power_good !== 1'b1; n++) cyc(1);
		bound(n);
		check({i_brps_link_if.supplies_on, i_brps_link_if.io_clamp_rail}, 8'h03);
	endtask

	// Start-up events after any release of the non-sticky reset
	task await_release(input logic eep);
		for (n = 0; n < LIM && o_link_train_start !== 1'b1; n++) cyc(1);
		bound(n);
		check(o_straps_q, straps);
		check(o_eeprom_load_start, eep);
		check(o_link_train_en, 1'b1);
		check({o_secondary_bus_reset_out, o_nonsticky_rst}, 8'h00);
		cyc(1);
		check({o_link_train_start, o_eeprom_load_start}, 8'h00);
	endtask

	initial begin
		cyc(10);
		i_srst = 1'b0;
		cyc(1);
		check({o_full_rst, o_secondary_bus_reset_out}, 8'h03);
		check(o_straps_q, brps_pkg::STRAP_RESET);
		$display("test reset done");
		// Supply one code short of stable, then at the threshold
		supply = 8'hb3;
		straps = 8'ha5;
		i_eeprom_present = 1'b1;
		power_up();
		cyc(1400);
		check({o_full_rst, o_secondary_bus_reset_out}, 8'h03);
		supply = 8'hb4;
		for (n = 0; n < LIM && o_full_rst !== 1'b0; n++) cyc(1);
		bound(n);
		check(8'(n >= brps_pkg::POR_CLK_DELAY_CYC && n <= brps_pkg::POR_CLK_DELAY_CYC + 12), 8'h01);
		await_release(1'b1);
		$display("test power-on done");
		// Global reset: immediate, full clear, new straps
		straps = 8'h3c;
		i_eeprom_present = 1'b0;
		cyc(2);
		check(o_straps_q, 8'ha5);
		i_global_reset_req = 1'b1;
		for (n = 0; n < LIM && i_brps_link_if.global_reset_n !== 1'b0; n++) cyc(1);
		bound(n);
		check(o_full_rst, 1'b1);
		cyc(1);
		check({o_secondary_bus_reset_out, o_link_train_en, o_perst_seen}, 8'h04);
		cyc(3);
		i_global_reset_req = 1'b0;
		await_release(1'b0);
		$display("test global reset done");
		// Power down and up: non-sticky reset only, sticky flag kept
		straps = 8'h5a;
		i_eeprom_present = 1'b1;
		i_power_on = 1'b0;
		for (n = 0; n < LIM && o_secondary_bus_reset_out !== 1'b1; n++) cyc(1);
		bound(n);
		cyc(1);
		check({o_full_rst, o_perst_seen}, 8'h01);
		for (n = 0; n < LIM && o_seq_busy !== 1'b0; n++) cyc(1);
		bound(n);
		check({i_brps_link_if.perst_n, i_brps_link_if.io_clamp_rail}, 8'h00);
		check(i_brps_link_if.supplies_on, 1'b0);
		power_up();
		await_release(1'b1);
		check(o_perst_seen, 1'b1);
		$display("test power cycle done");
		// Global reset clears the sticky flag, a supply dip restarts power-on
		i_global_reset_req = 1'b1;
		cyc(2);
		check({o_full_rst, o_perst_seen}, 8'h02);
		i_global_reset_req = 1'b0;
		await_release(1'b1);
		supply = 8'hb3;
		cyc(2);
		check({o_full_rst, o_secondary_bus_reset_out}, 8'h03);
		$display("test late resets done");
		give_verdict();
	end
endmodule // tb_bridge_reset_power_sequencing

//--- logic/brps_bridge.sv
// Summary of operation
// - System asserts reset, powers, clamps, then clocks
// - Reset held 100 us after stable clock
// - Reset held 100 ms after power applied
// - Power-down: reset, clock, clamp, supplies off
// - Power stable when core supply reaches 90%
// - Release power-on reset 10 us after clocks
// - Power-on reset clears everything, holds bus reset
// - Global reset low acts asynchronously as power-on
// - Global reset clears all state, drives bus reset
// - Latch straps on each non-sticky reset release
// - Start EEPROM download if one is present
// - Start link training within 80 ms of release
// - Fundamental reset clears non-sticky state and bus
`timescale 1ns/1ns
module brps_bridge (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Link to system reset controller
	brps_link_if.dev link,
	// Supply monitor and straps
	input wire logic [7:0] i_core_supply_sense,
	input wire logic [brps_pkg::STRAP_W-1:0] i_straps,
	input wire logic i_eeprom_present,
	// Resets to the core
	output logic o_full_rst,
	output logic o_nonsticky_rst,
	output logic o_secondary_bus_reset_out,
	// Start-up events and state
	output logic [brps_pkg::STRAP_W-1:0] o_straps_q,
	output logic o_eeprom_load_start,
	output logic o_link_train_start,
	output logic o_link_train_en,
	output logic o_perst_seen
);
	// Power-on reset generator
	brps_pkg::brps_por_state_type por_state_q;
	brps_pkg::brps_por_state_type por_state_d;
	logic [brps_pkg::POR_CNT_W-1:0] por_cnt_q;
	logic [brps_pkg::POR_CNT_W-1:0] por_cnt_d;
	logic por_q;
	// Link synchronisers and edge history
	logic [1:0] global_reset_n_sync_q;
	logic [1:0] perst_sync_q;
	logic [1:0] refclk_sync_q;
	logic refclk_prev_q;
	logic nonsticky_prev_q;
	// Latched straps and start-up state
	logic [brps_pkg::STRAP_W-1:0] straps_q;
	logic eeprom_start_q;
	logic train_start_q;
	logic train_en_q;
	logic perst_seen_q;
	// Decoded conditions
	logic supply_ok;
	logic clk_edge;
	logic delay_done;
	logic por_hold;
	logic global_reset_n_active;
	logic perst_active;
	logic full_rst;
	logic nonsticky_rst;
	logic clear_all;
	logic release_evt;

	// Supply level and reference clock activity
	assign supply_ok = i_core_supply_sense >= brps_pkg::SUPPLY_STABLE_CODE;
	assign clk_edge = refclk_sync_q[1] ^ refclk_prev_q;
	assign delay_done =
		por_cnt_q == brps_pkg::POR_CNT_W'(brps_pkg::POR_CLK_DELAY_CYC - 1);
	assign por_hold = por_state_d != brps_pkg::POR_DONE;

	// Power-on reset sequencing
	always_comb begin
		por_state_d = por_state_q;
		por_cnt_d = por_cnt_q;
		case (por_state_q)
			brps_pkg::POR_WAIT_POWER: begin
				if (supply_ok) begin
					por_state_d = brps_pkg::POR_WAIT_CLOCK;
				end
			end
			brps_pkg::POR_WAIT_CLOCK: begin
				if (!supply_ok) begin
					por_state_d = brps_pkg::POR_WAIT_POWER;
				end else if (clk_edge) begin
					por_state_d = brps_pkg::POR_DELAY;
					por_cnt_d = '0;
				end
			end
			brps_pkg::POR_DELAY: begin
				if (!supply_ok) begin
					por_state_d = brps_pkg::POR_WAIT_POWER;
				end else if (delay_done) begin
					por_state_d = brps_pkg::POR_DONE;
				end else begin
					por_cnt_d = por_cnt_q + 1'b1;
				end
			end
			brps_pkg::POR_DONE: begin
				if (!supply_ok) begin
					por_state_d = brps_pkg::POR_WAIT_POWER;
				end
			end
			default: begin
				por_state_d = brps_pkg::POR_WAIT_POWER;
			end
		endcase
	end

	// Power-on state, counter and reset level
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			por_state_q <= brps_pkg::POR_WAIT_POWER;
			por_cnt_q <= '0;
			por_q <= 1'b1;
		end else begin
			por_state_q <= por_state_d;
			por_cnt_q <= por_cnt_d;
			por_q <= por_hold;
		end
	end

	// Global reset: asserts at once, releases after two clean edges
	always_ff @(posedge i_ref_clk or negedge link.global_reset_n) begin
		if (!link.global_reset_n) begin
			global_reset_n_sync_q <= 2'b00;
		end else if (i_srst) begin
			global_reset_n_sync_q <= 2'b00;
		end else begin
			global_reset_n_sync_q <= {global_reset_n_sync_q[0], 1'b1};
		end
	end

	// Pin synchronisers for fundamental reset and clock activity
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			perst_sync_q <= 2'b00;
			refclk_sync_q <= 2'b00;
			refclk_prev_q <= 1'b0;
		end else begin
			perst_sync_q <= {perst_sync_q[0], link.perst_n};
			refclk_sync_q <= {refclk_sync_q[0], link.refclk};
			refclk_prev_q <= refclk_sync_q[1];
		end
	end

	// Synchronised link requests, active high; only the second stage is read
	assign global_reset_n_active = ~global_reset_n_sync_q[1];
	assign perst_active = ~perst_sync_q[1];

	// Reset tree; straps and sticky bits follow the full reset only
	assign full_rst = por_q | global_reset_n_active;
	assign nonsticky_rst = full_rst | perst_active;
	assign clear_all = i_srst | full_rst;
	assign release_evt = nonsticky_prev_q & ~nonsticky_rst;

	// Release edge detection
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			nonsticky_prev_q <= 1'b1;
		end else begin
			nonsticky_prev_q <= nonsticky_rst;
		end
	end

	// Sticky record of a fundamental reset, cleared only by full reset
	always_ff @(posedge i_ref_clk) begin
		if (clear_all) begin
			perst_seen_q <= 1'b0;
		end else if (perst_active) begin
			perst_seen_q <= 1'b1;
		end
	end

	// Strap latch and start-up actions on reset release
	always_ff @(posedge i_ref_clk) begin
		if (clear_all) begin
			straps_q <= brps_pkg::STRAP_RESET;
			eeprom_start_q <= 1'b0;
			train_start_q <= 1'b0;
			train_en_q <= 1'b0;
		end else if (nonsticky_rst) begin
			eeprom_start_q <= 1'b0;
			train_start_q <= 1'b0;
			train_en_q <= 1'b0;
		end else begin
			if (release_evt) begin
				straps_q <= i_straps;
			end
			eeprom_start_q <= release_evt & i_eeprom_present;
			train_start_q <= release_evt;
			if (release_evt) begin
				train_en_q <= 1'b1;
			end
		end
	end

	// Reset outputs
	assign o_full_rst = full_rst;
	assign o_nonsticky_rst = nonsticky_rst;
	assign o_secondary_bus_reset_out = nonsticky_rst;

	// Start-up outputs
	assign o_straps_q = straps_q;
	assign o_eeprom_load_start = eeprom_start_q;
	assign o_link_train_start = train_start_q;
	assign o_link_train_en = train_en_q;
	assign o_perst_seen = perst_seen_q;
endmodule // brps_bridge

//--- logic/brps_link_if.sv
`timescale 1ns/1ns
interface brps_link_if;
	logic perst_n;
	logic global_reset_n;
	logic refclk;
	logic supplies_on;
	logic io_clamp_rail;

	// Bridge end
	modport dev (
		input perst_n,
		input global_reset_n,
		input refclk,
		input supplies_on,
		input io_clamp_rail
	);

	// System reset controller end
	modport sys (
		output perst_n,
		output global_reset_n,
		output refclk,
		output supplies_on,
		output io_clamp_rail
	);
endinterface

//--- logic/brps_pkg.sv
package brps_pkg;
	// Core clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;

	// Supply monitor: sense code is an ADC reading, nominal level below
	localparam logic [7:0] SUPPLY_NOMINAL_CODE = 8'hc8;
	localparam int SUPPLY_STABLE_PCT = 90;
	localparam logic [7:0] SUPPLY_STABLE_CODE =
		8'((int'(SUPPLY_NOMINAL_CODE) * SUPPLY_STABLE_PCT + 99) / 100);

	// Delay from first clock activity to power-on reset release
	localparam int POR_CLK_DELAY_US = 10;
	localparam int POR_CLK_DELAY_CYC =
		(POR_CLK_DELAY_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int POR_CNT_W = 11;

	// Fundamental reset hold times seen by the system
	localparam int PERST_CLK_WAIT_US = 100;
	localparam int PERST_PWR_WAIT_MS = 100;
	localparam int PERST_CLK_WAIT_CYC =
		(PERST_CLK_WAIT_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PERST_PWR_WAIT_CYC =
		(PERST_PWR_WAIT_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOST_CNT_W = 24;

	// Link training must start within this bound after release
	localparam int LINK_TRAIN_LIMIT_MS = 80;

	// Host supply and rail settling per step, reference clock half period
	localparam int STEP_CYC = 16;
	localparam int STEP_CNT_W = 5;
	localparam int REFCLK_HALF_CYC = 2;
	localparam int REFCLK_CNT_W = 2;

	// Static configuration straps
	localparam int STRAP_W = 8;
	localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;

	// Power-on reset generator states
	typedef enum logic [1:0] {
		POR_WAIT_POWER,
		POR_WAIT_CLOCK,
		POR_DELAY,
		POR_DONE
	} brps_por_state_type;

	// System power sequencer states
	typedef enum logic [3:0] {
		SEQ_OFF,
		SEQ_SUPPLY,
		SEQ_CLAMP,
		SEQ_CLOCK,
		SEQ_WAIT,
		SEQ_RUN,
		SEQ_DN_PERST,
		SEQ_DN_CLOCK,
		SEQ_DN_CLAMP
	} brps_seq_state_type;
endpackage

//--- logic/brps_system.sv
`timescale 1ns/1ns
module brps_system #(
	parameter int PWR_WAIT_CYC = brps_pkg::PERST_PWR_WAIT_CYC,
	parameter int CLK_WAIT_CYC = brps_pkg::PERST_CLK_WAIT_CYC
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_srst,
	// Requests
	input wire logic i_power_on,
	input wire logic i_global_reset_req,
	// Link to bridge
	brps_link_if.sys link,
	// Status
	output logic o_power_good,
	output logic o_seq_busy
);
	brps_pkg::brps_seq_state_type state_q;
	brps_pkg::brps_seq_state_type state_d;
	logic [brps_pkg::HOST_CNT_W-1:0] pwr_cnt_q;
	logic [brps_pkg::HOST_CNT_W-1:0] clk_cnt_q;
	logic [brps_pkg::STEP_CNT_W-1:0] step_cnt_q;
	logic [brps_pkg::REFCLK_CNT_W-1:0] div_q;
	logic refclk_q;
	logic global_reset_n_n_q;
	logic step_done;
	logic pwr_done;
	logic clk_done;
	logic supplies_on;
	logic clamp_on;
	logic clock_on;
	logic perst_high;

	assign step_done = step_cnt_q == brps_pkg::STEP_CNT_W'(brps_pkg::STEP_CYC - 1);
	assign pwr_done = pwr_cnt_q >= brps_pkg::HOST_CNT_W'(PWR_WAIT_CYC);
	assign clk_done = clk_cnt_q >= brps_pkg::HOST_CNT_W'(CLK_WAIT_CYC);

	// Output levels per state
	assign supplies_on = state_q != brps_pkg::SEQ_OFF;
	// Clamp is off for the whole last step so it leaves before the supplies
	assign clamp_on = !(state_q inside {brps_pkg::SEQ_OFF, brps_pkg::SEQ_SUPPLY,
		brps_pkg::SEQ_DN_CLAMP});
	assign clock_on = state_q inside {brps_pkg::SEQ_CLOCK, brps_pkg::SEQ_WAIT,
		brps_pkg::SEQ_RUN, brps_pkg::SEQ_DN_PERST};
	assign perst_high = state_q == brps_pkg::SEQ_RUN;

	// Sequence steps
	always_comb begin
		state_d = state_q;
		case (state_q)
			brps_pkg::SEQ_OFF: if (i_power_on) state_d = brps_pkg::SEQ_SUPPLY;
			brps_pkg::SEQ_SUPPLY: if (step_done) state_d = brps_pkg::SEQ_CLAMP;
			brps_pkg::SEQ_CLAMP: if (step_done) state_d = brps_pkg::SEQ_CLOCK;
			brps_pkg::SEQ_CLOCK: state_d = brps_pkg::SEQ_WAIT;
			brps_pkg::SEQ_WAIT: begin
				if (!i_power_on) begin
					state_d = brps_pkg::SEQ_DN_PERST;
				end else if (pwr_done && clk_done) begin
					state_d = brps_pkg::SEQ_RUN;
				end
			end
			brps_pkg::SEQ_RUN: if (!i_power_on) state_d = brps_pkg::SEQ_DN_PERST;
			brps_pkg::SEQ_DN_PERST: if (step_done) state_d = brps_pkg::SEQ_DN_CLOCK;
			brps_pkg::SEQ_DN_CLOCK: if (step_done) state_d = brps_pkg::SEQ_DN_CLAMP;
			brps_pkg::SEQ_DN_CLAMP: if (step_done) state_d = brps_pkg::SEQ_OFF;
			default: state_d = brps_pkg::SEQ_OFF;
		endcase
	end

	// State, step timer and hold timers
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			state_q <= brps_pkg::SEQ_OFF;
			step_cnt_q <= '0;
			pwr_cnt_q <= '0;
			clk_cnt_q <= '0;
		end else begin
			state_q <= state_d;
			step_cnt_q <= (state_d != state_q) ? '0 : step_cnt_q + 1'b1;
			if (!supplies_on) begin
				pwr_cnt_q <= '0;
			end else if (!pwr_done) begin
				pwr_cnt_q <= pwr_cnt_q + 1'b1;
			end
			if (!clock_on) begin
				clk_cnt_q <= '0;
			end else if (!clk_done) begin
				clk_cnt_q <= clk_cnt_q + 1'b1;
			end
		end
	end

	// Reference clock divider and global reset drive
	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			div_q <= '0;
			refclk_q <= 1'b0;
			global_reset_n_n_q <= 1'b0;
		end else begin
			global_reset_n_n_q <= !i_global_reset_req;
			if (!clock_on) begin
				div_q <= '0;
				refclk_q <= 1'b0;
			end else if (div_q == brps_pkg::REFCLK_CNT_W'(brps_pkg::REFCLK_HALF_CYC - 1)) begin
				div_q <= '0;
				refclk_q <= !refclk_q;
			end else begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	assign link.perst_n = perst_high;
	assign link.global_reset_n = global_reset_n_n_q;
	assign link.refclk = refclk_q;
	assign link.supplies_on = supplies_on;
	assign link.io_clamp_rail = clamp_on;
	assign o_power_good = perst_high;
	assign o_seq_busy = !(state_q inside {brps_pkg::SEQ_OFF, brps_pkg::SEQ_RUN});
endmodule // brps_system
